// ---- i2c_host_model.sv ----
/*
  Behavioural I2C host that drives the regulator register slice.
  Assumes an open-drain sda wire resolved outside, with a pull-up,
  and a free-running core_clk to time its bus phases.
*/
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model (
  input wire logic core_clk,
  input wire logic sdaLine,
  output var logic scl,
  output var logic sdaLow
);
  // Half bus phase in core clocks; the bench varies it at random from 6 to 12
  int halfCyc = 8;

  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // Phases stay above the slave's 3-clock synchroniser
  task automatic pause();
    repeat (halfCyc) @(posedge core_clk);
  endtask

  // Start or repeated start; the host takes control of the bus
  task automatic start();
    // Align to a rising edge so every line change follows one
    @(posedge core_clk);
    if (scl == 1'b0) begin
      sdaLow <= 1'b0;
      pause();
      scl <= 1'b1;
      pause();
    end
    sdaLow <= 1'b1;
    pause();
    scl <= 1'b0;
    pause();
  endtask

  // Stop: data rises while the clock is high
  task automatic stop();
    sdaLow <= 1'b1;
    pause();
    scl <= 1'b1;
    pause();
    sdaLow <= 1'b0;
    pause();
  endtask

  // One clock pulse; a released line reads high through the pull-up
  task automatic bit_io(input logic b, output logic r);
    sdaLow <= ~b;
    pause();
    scl <= 1'b1;
    pause();
    r = sdaLine;
    scl <= 1'b0;
    pause();
  endtask

  // Byte out MSB first, returns the acknowledge level
  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, nak);
  endtask

  // Byte in MSB first; a high acknowledge ends the read
  task automatic recv_byte(input logic nak, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(nak, r);
  endtask
endmodule

`default_nettype wire

// ---- regulator_control_pkg.sv ----
/*
  Constants, state encodings and the state record for the regulator
  control register slice (target code, current limits, enable/mode).
  Assumes a single 125 MHz core clock; no timing counts are needed.
*/
`default_nettype none
package regulator_control_pkg;

  // Register map
  localparam logic [7:0] TARGET_OFFSET = 8'h07;
  localparam logic [7:0] LIMIT_OFFSET = 8'h08;
  localparam logic [7:0] ENABLE_OFFSET = 8'h09;
  localparam logic [6:0] TARGET_RESET = 7'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h55;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] LIMIT_MASK = 8'h55;
  localparam logic [7:0] ENABLE_MASK = 8'hDF;

  // Field positions
  localparam int BOOST_PWM_BIT = 7;
  localparam int BUCK_PWM_BIT = 6;
  localparam int BUCK_ON_BIT = 4;
  localparam int LDO_FOUR_ON_BIT = 3;
  localparam int LDO_THREE_ON_BIT = 2;
  localparam int LDO_TWO_ON_BIT = 1;
  localparam int LDO_ONE_ON_BIT = 0;
  localparam int LDO_ONE_LIMIT_BIT = 0;
  localparam int LDO_TWO_LIMIT_BIT = 2;
  localparam int LDO_THREE_LIMIT_BIT = 4;
  localparam int LDO_FOUR_LIMIT_BIT = 6;

  // Target code map
  localparam logic [6:0] CODE_DEFAULT = 7'h00;
  localparam logic [6:0] CODE_FIRST = 7'h0F;
  localparam logic [6:0] CODE_UPPER_FIRST = 7'h24;
  localparam logic [6:0] CODE_LAST = 7'h73;
  localparam logic [11:0] MV_AT_FIRST = 12'h0320;
  localparam logic [11:0] MV_AT_UPPER_FIRST = 12'h052D;
  localparam logic [11:0] MV_STEP = 12'h0019;

  // Sequencing
  localparam logic [2:0] SLOT_HOST = 3'h0;

  // Bus
  localparam logic [6:0] DEFAULT_DEVICE_ADDRESS = 7'h2A; // Arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_RECEIVE, BUS_ACK, BUS_SEND, BUS_HOST_ACK
  } bus_state_e;

  typedef enum logic [1:0] {BYTE_ADDR, BYTE_POINTER, BYTE_DATA} byte_kind_e;

  typedef struct packed {
    logic sclMeta;
    logic sdaMeta;
    logic sclSync;
    logic sdaSync;
    logic sclLast;
    logic sdaLast;
    bus_state_e st;
    byte_kind_e kind;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic readMode;
    logic sdaOe_n;
    logic [6:0] targetCode;
    logic [7:0] limitSel;
    logic [7:0] enMode;
    logic boostPwm;
    logic buckPwm;
    logic [3:0] limitOut;
    logic buckOn;
    logic [3:0] ldoOn;
    logic [11:0] targetMv;
    logic targetDefault;
    logic targetReserved;
  } regs_s;

endpackage

`default_nettype wire

// ---- regulator_control_regs.sv ----
/*
  I2C register slave for the regulator control slice, with the
  enable resolution between host requests and start-up slots.
  Assumes scl/sda arrive asynchronously from pins, the sequencer's
  slot selects and reached-slot count come from core_clk logic, and
  an external open-drain pad resolves sda from sdaOe_n.
*/
`timescale 1ns/100ps
`default_nettype none

module regulator_control_regs #(
  parameter logic [6:0] DEVICE_ADDRESS =
    regulator_control_pkg::DEFAULT_DEVICE_ADDRESS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  input wire logic [2:0] buckSlotSelect,
  input wire logic [2:0] ldoOneSlotSelect,
  input wire logic [2:0] ldoTwoSlotSelect,
  input wire logic [2:0] ldoThreeSlotSelect,
  input wire logic [2:0] ldoFourSlotSelect,
  input wire logic [2:0] startupSlotReached,
  output logic boostForcedPwm,
  output logic buckForcedPwm,
  output logic ldoOneLimitSelect,
  output logic ldoTwoLimitSelect,
  output logic ldoThreeLimitSelect,
  output logic ldoFourLimitSelect,
  output logic buckOn,
  output logic ldoOneOn,
  output logic ldoTwoOn,
  output logic ldoThreeOn,
  output logic ldoFourOn,
  output logic [6:0] ldoFourTargetCode,
  output logic [11:0] ldoFourTargetMv,
  output logic ldoFourTargetDefault,
  output logic ldoFourTargetReserved
);

  regulator_control_pkg::regs_s r;
  regulator_control_pkg::regs_s n;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic [7:0] readByte;

  // Register readback; unmapped pointers and unused bits read zero
  function automatic logic [7:0] readReg(input logic [7:0] ptr,
                                         input regulator_control_pkg::regs_s s);
    case (ptr)
      regulator_control_pkg::TARGET_OFFSET: readReg = {1'b0, s.targetCode};
      regulator_control_pkg::LIMIT_OFFSET: readReg = s.limitSel;
      regulator_control_pkg::ENABLE_OFFSET: readReg = s.enMode;
      default: readReg = 8'h00;
    endcase
  endfunction

  // Host request while slot is 000, else on once its slot is reached
  function automatic logic slotOn(input logic [2:0] slot,
                                  input logic request,
                                  input logic [2:0] reached);
    if (slot == regulator_control_pkg::SLOT_HOST) begin
      slotOn = request;
    end else begin
      slotOn = (slot <= reached);
    end
  endfunction

  // Millivolts for a valid code; 25 mV per code above 0x0F
  function automatic logic [11:0] codeMv(input logic [6:0] code);
    logic [6:0] steps;
    steps = code - regulator_control_pkg::CODE_FIRST;
    codeMv = regulator_control_pkg::MV_AT_FIRST +
             12'({5'h00, steps} * regulator_control_pkg::MV_STEP);
  endfunction

  // Edge and bus condition detection on synchronised pins only
  assign sclRise = r.sclSync & ~r.sclLast;
  assign sclFall = ~r.sclSync & r.sclLast;
  assign startDet = r.sclSync & r.sclLast & r.sdaLast & ~r.sdaSync;
  assign stopDet = r.sclSync & r.sclLast & ~r.sdaLast & r.sdaSync;
  assign readByte = readReg(r.ptr, r);

  // Next state: bus engine, register writes and output resolution
  always_comb begin
    n = r;
    n.sclMeta = scl;
    n.sdaMeta = sdaIn;
    n.sclSync = r.sclMeta;
    n.sdaSync = r.sdaMeta;
    n.sclLast = r.sclSync;
    n.sdaLast = r.sdaSync;
    if (startDet) begin
      // A repeated start also lands here, keeping the pointer
      n.st = regulator_control_pkg::BUS_RECEIVE;
      n.kind = regulator_control_pkg::BYTE_ADDR;
      n.bitCnt = 4'h0;
      n.sdaOe_n = 1'b1;
    end else if (stopDet) begin
      n.st = regulator_control_pkg::BUS_IDLE;
      n.sdaOe_n = 1'b1;
    end else begin
      case (r.st)
        regulator_control_pkg::BUS_RECEIVE: begin
          if (sclRise) begin
            n.shift = {r.shift[6:0], r.sdaSync};
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall &&
                       r.bitCnt == regulator_control_pkg::BITS_PER_BYTE) begin
            n.st = regulator_control_pkg::BUS_ACK;
            n.sdaOe_n = 1'b0;
            case (r.kind)
              regulator_control_pkg::BYTE_ADDR: begin
                n.readMode = r.shift[0];
                n.kind = regulator_control_pkg::BYTE_POINTER;
                if (r.shift[7:1] != DEVICE_ADDRESS) begin
                  // Not ours: stay off the bus until the next start
                  n.st = regulator_control_pkg::BUS_IDLE;
                  n.sdaOe_n = 1'b1;
                end
              end
              regulator_control_pkg::BYTE_POINTER: begin
                n.ptr = r.shift;
                n.kind = regulator_control_pkg::BYTE_DATA;
              end
              default: begin
                // Data byte: masked write, then auto-increment
                case (r.ptr)
                  regulator_control_pkg::TARGET_OFFSET: begin
                    n.targetCode = r.shift[6:0];
                  end
                  regulator_control_pkg::LIMIT_OFFSET: begin
                    n.limitSel = r.shift &
                      regulator_control_pkg::LIMIT_MASK;
                  end
                  regulator_control_pkg::ENABLE_OFFSET: begin
                    n.enMode = r.shift &
                      regulator_control_pkg::ENABLE_MASK;
                  end
                  default: begin
                  end
                endcase
                n.ptr = r.ptr + 8'h01;
              end
            endcase
          end
        end
        regulator_control_pkg::BUS_ACK: begin
          if (sclFall) begin
            n.bitCnt = 4'h0;
            if (r.readMode) begin
              n.st = regulator_control_pkg::BUS_SEND;
              n.shift = readByte;
              n.ptr = r.ptr + 8'h01;
              n.sdaOe_n = readByte[7];
            end else begin
              n.st = regulator_control_pkg::BUS_RECEIVE;
              n.sdaOe_n = 1'b1;
            end
          end
        end
        regulator_control_pkg::BUS_SEND: begin
          if (sclRise) begin
            n.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (r.bitCnt == regulator_control_pkg::BITS_PER_BYTE) begin
              n.st = regulator_control_pkg::BUS_HOST_ACK;
              n.sdaOe_n = 1'b1;
            end else begin
              n.shift = {r.shift[6:0], 1'b0};
              n.sdaOe_n = r.shift[6];
            end
          end
        end
        regulator_control_pkg::BUS_HOST_ACK: begin
          if (sclRise && r.sdaSync) begin
            // Host declined more data; wait for stop or start
            n.st = regulator_control_pkg::BUS_IDLE;
          end else if (sclFall) begin
            n.st = regulator_control_pkg::BUS_SEND;
            n.bitCnt = 4'h0;
            n.shift = readByte;
            n.ptr = r.ptr + 8'h01;
            n.sdaOe_n = readByte[7];
          end
        end
        default: begin
          n.sdaOe_n = 1'b1;
        end
      endcase
    end

    // Converter modes and current limits straight from the registers
    n.boostPwm = r.enMode[regulator_control_pkg::BOOST_PWM_BIT];
    n.buckPwm = r.enMode[regulator_control_pkg::BUCK_PWM_BIT];
    n.limitOut = {r.limitSel[regulator_control_pkg::LDO_FOUR_LIMIT_BIT],
                  r.limitSel[regulator_control_pkg::LDO_THREE_LIMIT_BIT],
                  r.limitSel[regulator_control_pkg::LDO_TWO_LIMIT_BIT],
                  r.limitSel[regulator_control_pkg::LDO_ONE_LIMIT_BIT]};

    // On/off resolution: host bit or start-up slot
    n.buckOn = slotOn(buckSlotSelect,
      r.enMode[regulator_control_pkg::BUCK_ON_BIT],
      startupSlotReached);
    n.ldoOn[3] = slotOn(ldoFourSlotSelect,
      r.enMode[regulator_control_pkg::LDO_FOUR_ON_BIT],
      startupSlotReached);
    n.ldoOn[2] = slotOn(ldoThreeSlotSelect,
      r.enMode[regulator_control_pkg::LDO_THREE_ON_BIT],
      startupSlotReached);
    n.ldoOn[1] = slotOn(ldoTwoSlotSelect,
      r.enMode[regulator_control_pkg::LDO_TWO_ON_BIT],
      startupSlotReached);
    n.ldoOn[0] = slotOn(ldoOneSlotSelect,
      r.enMode[regulator_control_pkg::LDO_ONE_ON_BIT],
      startupSlotReached);

    // Target decode; reserved codes report zero millivolts
    n.targetDefault =
      (r.targetCode == regulator_control_pkg::CODE_DEFAULT);
    n.targetReserved = ~n.targetDefault &&
      (r.targetCode < regulator_control_pkg::CODE_FIRST ||
       r.targetCode > regulator_control_pkg::CODE_LAST);
    if (n.targetDefault || n.targetReserved) begin
      n.targetMv = 12'h000;
    end else begin
      n.targetMv = codeMv(r.targetCode);
    end
  end

  // Single register stage; idle pins read high out of reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.sclMeta <= 1'b1;
      r.sdaMeta <= 1'b1;
      r.sclSync <= 1'b1;
      r.sdaSync <= 1'b1;
      r.sclLast <= 1'b1;
      r.sdaLast <= 1'b1;
      r.sdaOe_n <= 1'b1;
      r.targetCode <= regulator_control_pkg::TARGET_RESET;
      r.limitSel <= regulator_control_pkg::LIMIT_RESET;
      r.enMode <= regulator_control_pkg::ENABLE_RESET;
      r.limitOut <= 4'hF;
      r.targetDefault <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Open-drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe_n = r.sdaOe_n;
  assign boostForcedPwm = r.boostPwm;
  assign buckForcedPwm = r.buckPwm;
  assign ldoOneLimitSelect = r.limitOut[0];
  assign ldoTwoLimitSelect = r.limitOut[1];
  assign ldoThreeLimitSelect = r.limitOut[2];
  assign ldoFourLimitSelect = r.limitOut[3];
  assign buckOn = r.buckOn;
  assign ldoOneOn = r.ldoOn[0];
  assign ldoTwoOn = r.ldoOn[1];
  assign ldoThreeOn = r.ldoOn[2];
  assign ldoFourOn = r.ldoOn[3];
  assign ldoFourTargetCode = r.targetCode;
  assign ldoFourTargetMv = r.targetMv;
  assign ldoFourTargetDefault = r.targetDefault;
  assign ldoFourTargetReserved = r.targetReserved;

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence startSeen;
    startDet;
  endsequence

  sequence hostOwnsBuck;
    buckSlotSelect == regulator_control_pkg::SLOT_HOST;
  endsequence

  a_upper_target_mv: assert property (
    r.targetCode >= regulator_control_pkg::CODE_UPPER_FIRST &&
    r.targetCode <= regulator_control_pkg::CODE_LAST |=>
    ldoFourTargetMv == regulator_control_pkg::MV_AT_UPPER_FIRST +
      12'({5'h00, $past(r.targetCode) -
      regulator_control_pkg::CODE_UPPER_FIRST} * 12'h0019))
    else $error("target millivolts wrong for upper code");
  a_low_target_codes: assert property (
    r.targetCode < regulator_control_pkg::CODE_FIRST |=>
    ldoFourTargetMv == 12'h000 &&
    ldoFourTargetDefault == ($past(r.targetCode) == 7'h00) &&
    ldoFourTargetReserved == ($past(r.targetCode) != 7'h00))
    else $error("low target code decode wrong");
  a_limit_select_map: assert property (
    1'b1 |=> {ldoFourLimitSelect, ldoThreeLimitSelect,
      ldoTwoLimitSelect, ldoOneLimitSelect} ==
      {$past(r.limitSel[6]), $past(r.limitSel[4]),
      $past(r.limitSel[2]), $past(r.limitSel[0])})
    else $error("current limit select not following register");
  a_boost_pwm_mode: assert property (
    $rose(r.enMode[7]) |=> boostForcedPwm)
    else $error("boost forced pwm not applied");
  a_buck_pwm_mode: assert property (
    $fell(r.enMode[6]) |=> !buckForcedPwm)
    else $error("buck forced pwm not released");
  a_buck_host_switch: assert property (
    hostOwnsBuck |=> buckOn == $past(r.enMode[4]))
    else $error("buck does not follow host request");
  a_ldo_four_host: assert property (
    ldoFourSlotSelect == 3'h0 |=> ldoFourOn == $past(r.enMode[3]))
    else $error("regulator four does not follow host request");
  a_ldo_three_host: assert property (
    ldoThreeSlotSelect == 3'h0 |=> ldoThreeOn == $past(r.enMode[2]))
    else $error("regulator three does not follow host request");
  a_ldo_two_host: assert property (
    ldoTwoSlotSelect == 3'h0 |=> ldoTwoOn == $past(r.enMode[1]))
    else $error("regulator two does not follow host request");
  a_ldo_one_host: assert property (
    ldoOneSlotSelect == 3'h0 |=> ldoOneOn == $past(r.enMode[0]))
    else $error("regulator one does not follow host request");
  a_enable_reset_zero: assert property (
    disable iff (1'b0) rst |-> r.enMode == 8'h00)
    else $error("enable register not zero in reset");
  a_slot_auto_on: assert property (
    buckSlotSelect != 3'h0 |=>
    buckOn == ($past(buckSlotSelect) <= $past(startupSlotReached)))
    else $error("buck slot start-up resolution wrong");
  a_unused_bits_zero: assert property (
    r.enMode[5] == 1'b0 && (r.limitSel & 8'hAA) == 8'h00)
    else $error("unused register bit set");
  a_start_restarts: assert property (
    startSeen |=> r.st == regulator_control_pkg::BUS_RECEIVE &&
      r.bitCnt == 4'h0 && sdaOe_n)
    else $error("start condition not restarting receive");

endmodule

`default_nettype wire

// ---- regulator_control_regs_test.sv ----
/*
  Self-checking bench for the regulator control register slice.
  Assumes the I2C host model beside it, the default device address
  and a bench-made sequencer (slot selects and reached slot).
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin \
  samplesChecked++; \
  if ((got) !== (exp)) begin \
    errorCnt++; \
    $display("BAD %0t got %h expected %h", $time, got, exp); \
  end \
end

module regulator_control_regs_test;
  localparam logic [6:0] ADDR = regulator_control_pkg::DEFAULT_DEVICE_ADDRESS;
  localparam logic [6:0] CODES [9] = '{7'h00, 7'h01, 7'h0E, 7'h0F, 7'h23,
    7'h24, 7'h73, 7'h74, 7'h7F};
  logic core_clk = 1'b0;
  logic rst;
  logic scl, sdaLow, sdaOut, sdaOe_n;
  logic [2:0] slotSel [5] = '{default: 3'h0};
  logic [2:0] reached = 3'h0;
  logic boostForcedPwm, buckForcedPwm, buckOn;
  wire logic [3:0] limOut;
  wire logic [3:0] ldoOn;
  logic [6:0] ldoFourTargetCode;
  logic [11:0] ldoFourTargetMv;
  logic ldoFourTargetDefault, ldoFourTargetReserved;
  logic [7:0] shTgt, shLim, shEn;
  int errorCnt = 0;
  int samplesChecked = 0;
  // Open-drain wire with pull-up: low if either party pulls
  wire logic sdaLine = sdaLow ? 1'b0 : (sdaOe_n ? 1'b1 : sdaOut);

  always #4 core_clk = ~core_clk;

  i2c_host_model i_host (.core_clk(core_clk), .sdaLine(sdaLine),
    .scl(scl), .sdaLow(sdaLow));

  regulator_control_regs i_dut (.core_clk(core_clk), .rst(rst),
    .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .buckSlotSelect(slotSel[0]), .ldoOneSlotSelect(slotSel[1]),
    .ldoTwoSlotSelect(slotSel[2]), .ldoThreeSlotSelect(slotSel[3]),
    .ldoFourSlotSelect(slotSel[4]), .startupSlotReached(reached),
    .boostForcedPwm(boostForcedPwm), .buckForcedPwm(buckForcedPwm),
    .ldoOneLimitSelect(limOut[0]), .ldoTwoLimitSelect(limOut[1]),
    .ldoThreeLimitSelect(limOut[2]), .ldoFourLimitSelect(limOut[3]),
    .buckOn(buckOn), .ldoOneOn(ldoOn[0]), .ldoTwoOn(ldoOn[1]),
    .ldoThreeOn(ldoOn[2]), .ldoFourOn(ldoOn[3]),
    .ldoFourTargetCode(ldoFourTargetCode),
    .ldoFourTargetMv(ldoFourTargetMv),
    .ldoFourTargetDefault(ldoFourTargetDefault),
    .ldoFourTargetReserved(ldoFourTargetReserved));

  // 0.800 V at code 0x0F, 25 mV a step; no voltage outside the map
  function automatic logic [11:0] exp_mv(input logic [6:0] c);
    if (c < 7'h0F || c > 7'h73) begin
      return 12'h000;
    end
    return 12'h320 + 12'(c - 7'h0F) * 12'h019;
  endfunction

  function automatic logic exp_rsv(input logic [6:0] c);
    return c != 7'h00 && (c < 7'h0F || c > 7'h73);
  endfunction

  // Host request rules only at slot zero, else the start-up slot
  function automatic logic exp_on(input logic [2:0] s, input logic req);
    return (s == 3'h0) ? req : (s <= reached);
  endfunction

  function automatic logic [7:0] shadow_of(input logic [7:0] p);
    case (p)
      8'h07: return shTgt;
      8'h08: return shLim;
      8'h09: return shEn;
      default: return 8'h00;
    endcase
  endfunction

  task automatic stop_test();
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] b);
    logic nak;
    i_host.send_byte(b, nak);
    `CHK(nak, 1'b0)
  endtask

  // Write one register and track what it should hold
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    i_host.start();
    put({ADDR, 1'b0});
    put(p);
    put(d);
    i_host.stop();
    case (p)
      8'h07: shTgt = d & 8'h7F;
      8'h08: shLim = d & 8'h55;
      8'h09: shEn = d & 8'hDF;
      default: ;
    endcase
  endtask

  // Burst read with pointer increment; last byte is refused by host
  task automatic read_check(input logic [7:0] p, input int n);
    logic [7:0] d;
    i_host.start();
    put({ADDR, 1'b0});
    put(p);
    i_host.start();
    put({ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      i_host.recv_byte(i == n - 1, d);
      `CHK(d, shadow_of(p + 8'(i)))
    end
    i_host.stop();
  endtask

  // Outputs settle one clock after their cause; sample mid-cycle
  task automatic check_all();
    repeat (3) @(negedge core_clk);
    `CHK(ldoFourTargetCode, shTgt[6:0])
    `CHK(ldoFourTargetMv, exp_mv(shTgt[6:0]))
    `CHK(ldoFourTargetDefault, shTgt == 8'h00)
    `CHK(ldoFourTargetReserved, exp_rsv(shTgt[6:0]))
    `CHK(limOut, {shLim[6], shLim[4], shLim[2], shLim[0]})
    `CHK(boostForcedPwm, shEn[7])
    `CHK(buckForcedPwm, shEn[6])
    `CHK(buckOn, exp_on(slotSel[0], shEn[4]))
    `CHK(ldoOn[3], exp_on(slotSel[4], shEn[3]))
    `CHK(ldoOn[2], exp_on(slotSel[3], shEn[2]))
    `CHK(ldoOn[1], exp_on(slotSel[2], shEn[1]))
    `CHK(ldoOn[0], exp_on(slotSel[1], shEn[0]))
  endtask

  // Hang guard
  initial begin
    repeat (95000) @(posedge core_clk);
    errorCnt++;
    stop_test();
  end

  // Main sequence
  initial begin
    logic nak;
    // A real edge at time zero, so state is defined at the first clock
    rst <= 1'b1;
    void'($urandom(27261));
    shTgt = 8'h00;
    shLim = 8'h55;
    shEn = 8'h00;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    check_all();
    read_check(8'h07, 3);
    // Every bit set: unused ones stay clear, unmapped reads give zero
    for (int p = 7; p < 10; p++) begin
      write_reg(8'(p), 8'hFF);
    end
    read_check(8'h06, 5);
    check_all();
    // Code map corners, with bit 7 set to prove it is dropped
    for (int i = 0; i < 9; i++) begin
      write_reg(8'h07, {1'b1, CODES[i]});
      check_all();
    end
    // Random codes at random bus pace
    repeat (8) begin
      i_host.halfCyc = 6 + $urandom_range(6);
      write_reg(8'h07, 8'($urandom));
      check_all();
    end
    // Random requests, limits and sequencer state
    repeat (16) begin
      @(posedge core_clk);
      foreach (slotSel[k]) begin
        slotSel[k] <= ($urandom_range(1) == 0) ? 3'h0 : 3'($urandom);
      end
      reached <= 3'($urandom);
      write_reg(8'h08, 8'($urandom));
      write_reg(8'h09, 8'($urandom));
      check_all();
      // Sequencer moves on with no bus traffic
      @(posedge core_clk);
      reached <= 3'($urandom);
      slotSel[0] <= 3'($urandom);
      check_all();
    end
    // Unmapped writes are acknowledged and dropped
    write_reg(8'h0A, 8'hFF);
    write_reg(8'h06, 8'hFF);
    read_check(8'h06, 5);
    // Foreign address: no acknowledge, rest of frame ignored
    i_host.start();
    i_host.send_byte({ADDR ^ 7'h01, 1'b0}, nak);
    `CHK(nak, 1'b1)
    i_host.send_byte(8'h09, nak);
    i_host.send_byte(~shEn, nak);
    i_host.stop();
    check_all();
    // Second reset in mid-run
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    shTgt = 8'h00;
    shLim = 8'h55;
    shEn = 8'h00;
    check_all();
    read_check(8'h07, 3);
    stop_test();
  end
endmodule

`default_nettype wire
